// file: shared/bic_pkg.sv
// Package for the bridge interrupt channel: source indices, reset values, carriers.
// Assumes one clock domain; all sources arrive as synchronous levels or pulses.
package bic_pkg;

	// Internal source indices
	localparam int SRC_PCI_ERR_LOG   = 0;
	localparam int SRC_MASTER_PARITY = 1;
	localparam int SRC_LOCAL_ERR_LOG = 2;
	localparam int SRC_DMA_LOCAL_ERR = 3;
	localparam int SRC_DMA_PCI_ERR   = 4;
	localparam int SRC_DMA_RESET     = 5;
	localparam int SRC_DMA_DONE      = 6;
	localparam int SRC_CFG_STATUS    = 7;
	localparam int SRC_MAILBOX0      = 8;
	localparam int SRC_LOCAL_PARITY  = 12;
	localparam int NUM_SRC           = 13;
	localparam int NUM_MB            = 4;

	// Hardware forwarding bit positions
	localparam int HW_PCI_IRQ   = 0;
	localparam int HW_PARITY    = 1;
	localparam int HW_SYSERR    = 2;
	localparam int HW_LOCAL_IRQ = 3;
	localparam int NUM_HW       = 4;

	// Reset values
	localparam logic [NUM_SRC-1:0] SRC_RST = 13'h0000;
	localparam logic [NUM_HW-1:0]  HW_RST  = 4'h0;

	// Direction encoding: 0 drives local pin, 1 drives PCI pin
	localparam logic DIR_LOCAL = 1'b0;
	localparam logic DIR_PCI   = 1'b1;

	// Per-source control carrier
	typedef struct packed {
		logic [NUM_SRC-1:0] en;
		logic [NUM_SRC-1:0] dir;
	} bic_src_cfg_t;

	// Mailbox write event carrier
	typedef struct packed {
		logic [NUM_MB-1:0] wr_pci;
		logic [NUM_MB-1:0] wr_local;
	} bic_mb_wr_t;

	// Pin pair for an open-drain interrupt line
	typedef struct packed {
		logic out;
		logic oe_n;
	} bic_pin_drv_t;

endpackage

// file: hw/bic_status_bit.sv
// Sticky status bit: set by a cause level, cleared by write-one.
// Assumes the cause is a synchronous level sampled every clock.
`timescale 1ns/1ps
module bic_status_bit (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic sys_rst_i,
	// Cause and clear
	input  wire logic set_i,
	input  wire logic hold_i,
	input  wire logic clr_i,
	// State
	output logic      status_o
);
	logic status_q;
	logic status_d;

	// Set wins over clear; a live cause blocks the clear
	assign status_d = set_i | hold_i | (status_q & ~clr_i);

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			status_q <= 1'b0;
		end else begin
			status_q <= status_d;
		end
	end

	assign status_o = status_q;

	AST_SET_WINS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(set_i | hold_i) |=> status_q) else $error("status lost a set");
	AST_CLR_OK: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(clr_i & ~set_i & ~hold_i) |=> ~status_q) else $error("status not cleared");
endmodule // bic_status_bit

// file: hw/bic_irq_channel.sv
// Interrupt channel: forwards hardware lines across the bridge and raises
// interrupts for internal events. Control bits arrive as plain ports.
// Assumes all inputs synchronous to core_clk_i; pins are open drain.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Two bidirectional interrupt pins, PCI and local
// - Hardware input forwards only when enabled
// - Forwarded hardware interrupts logged in status
// - Hardware routing works one direction only
// - Local pin held until PCI negated, cleared
// - Parity/system error lines assert local pin
// - Internal event interrupts only when enabled
// - Per-source direction bit selects target pin
// - Each internal source has readable status
// - Status uncleared while source flag set
// - PCI error log, master parity are sources
// - Four DMA sources, write-one flags
// - Combined config status source excludes master parity
// - Mailbox fires on opposite-side write only
// - Status bits clear by writing one
module bic_irq_channel (
	// Clock and reset
	input  wire logic                        core_clk_i,
	input  wire logic                        sys_rst_i,
	// PCI interrupt pin (open drain)
	input  wire logic                        pci_irq_pin_i,
	output logic                             pci_irq_pin_o,
	output logic                             pci_irq_pin_oe_n_o,
	// Local interrupt pin (open drain)
	input  wire logic                        local_irq_pin_i,
	output logic                             local_irq_pin_o,
	output logic                             local_irq_pin_oe_n_o,
	// PCI error lines, active low levels
	input  wire logic                        parity_line_n_i,
	input  wire logic                        syserr_line_n_i,
	// Hardware forwarding enables
	input  wire logic                        pci_irq_forward_en_i,
	input  wire logic                        parity_line_forward_en_i,
	input  wire logic                        syserr_line_forward_en_i,
	input  wire logic                        local_irq_forward_en_i,
	// Internal source control
	input  wire bic_pkg::bic_src_cfg_t       src_cfg_i,
	// Source flags, levels
	input  wire logic                        pci_error_log_flag_i,
	input  wire logic                        master_parity_flag_i,
	input  wire logic                        local_error_log_flag_i,
	input  wire logic [3:0]                  dma_flags_i,
	input  wire logic [4:0]                  cfg_err_bits_i,
	input  wire logic                        local_parity_err_i,
	// Mailbox write strobes, one-cycle pulses
	input  wire bic_pkg::bic_mb_wr_t         mb_wr_i,
	// Write-one-to-clear strobes
	input  wire logic [bic_pkg::NUM_SRC-1:0] src_status_clr_i,
	input  wire logic [bic_pkg::NUM_HW-1:0]  hw_status_clr_i,
	// Status outputs
	output logic      [bic_pkg::NUM_SRC-1:0] src_status_o,
	output logic      [bic_pkg::NUM_HW-1:0]  hw_status_o,
	output logic                             route_conflict_o
);
	//////////////////////////////////////////////////////////////////////////
	// Source levels
	wire logic [bic_pkg::NUM_SRC-1:0] src_level;
	wire logic [bic_pkg::NUM_SRC-1:0] src_pulse;
	wire logic [bic_pkg::NUM_MB-1:0]  mb_hit;
	wire logic [bic_pkg::NUM_SRC-1:0] src_status;
	wire logic [bic_pkg::NUM_HW-1:0]  hw_cause;
	wire logic [bic_pkg::NUM_HW-1:0]  hw_status;
	wire logic                        pci_fwd_on;
	wire logic                        local_fwd_on;
	wire logic                        drive_pci;
	wire logic                        drive_local;

	// Mailbox fires from the bus opposite its direction
	genvar m;
	generate
		for (m = 0; m < bic_pkg::NUM_MB; m++) begin : g_mb
			assign mb_hit[m] = (src_cfg_i.dir[bic_pkg::SRC_MAILBOX0 + m] == bic_pkg::DIR_LOCAL)
				? mb_wr_i.wr_pci[m] : mb_wr_i.wr_local[m];
		end
	endgenerate

	assign src_level[bic_pkg::SRC_PCI_ERR_LOG]   = pci_error_log_flag_i;
	assign src_level[bic_pkg::SRC_MASTER_PARITY] = master_parity_flag_i;
	assign src_level[bic_pkg::SRC_LOCAL_ERR_LOG] = local_error_log_flag_i;
	assign src_level[bic_pkg::SRC_DMA_DONE:bic_pkg::SRC_DMA_LOCAL_ERR] = dma_flags_i;
	// Master parity already has its own source
	assign src_level[bic_pkg::SRC_CFG_STATUS]    = |cfg_err_bits_i;
	assign src_level[bic_pkg::SRC_MAILBOX0+3:bic_pkg::SRC_MAILBOX0] = 4'h0;
	assign src_level[bic_pkg::SRC_LOCAL_PARITY]  = local_parity_err_i;

	assign src_pulse = {1'b0, mb_hit, 8'h00};

	//////////////////////////////////////////////////////////////////////////
	// Internal status bits
	genvar s;
	generate
		for (s = 0; s < bic_pkg::NUM_SRC; s++) begin : g_src
			bic_status_bit u_bit (
				.core_clk_i (core_clk_i),
				.sys_rst_i  (sys_rst_i),
				.set_i      (src_cfg_i.en[s] & src_pulse[s]),
				.hold_i     (src_cfg_i.en[s] & src_level[s]),
				.clr_i      (src_status_clr_i[s]),
				.status_o   (src_status[s])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// Hardware forwarding
	// PCI-to-local forwarding wins if software enables both directions
	assign pci_fwd_on   = pci_irq_forward_en_i | parity_line_forward_en_i
		| syserr_line_forward_en_i;
	assign local_fwd_on = local_irq_forward_en_i & ~pci_fwd_on;
	assign route_conflict_o = local_irq_forward_en_i & pci_fwd_on;

	// Local input ignored while we drive it ourselves, avoiding a latch-up loop
	assign hw_cause[bic_pkg::HW_PCI_IRQ]   = pci_irq_forward_en_i & ~pci_irq_pin_i
		& pci_irq_pin_oe_n_o;
	assign hw_cause[bic_pkg::HW_PARITY]    = parity_line_forward_en_i & ~parity_line_n_i;
	assign hw_cause[bic_pkg::HW_SYSERR]    = syserr_line_forward_en_i & ~syserr_line_n_i;
	assign hw_cause[bic_pkg::HW_LOCAL_IRQ] = local_fwd_on & ~local_irq_pin_i
		& local_irq_pin_oe_n_o;

	generate
		for (s = 0; s < bic_pkg::NUM_HW; s++) begin : g_hw
			bic_status_bit u_hw (
				.core_clk_i (core_clk_i),
				.sys_rst_i  (sys_rst_i),
				.set_i      (1'b0),
				.hold_i     (hw_cause[s]),
				.clr_i      (hw_status_clr_i[s]),
				.status_o   (hw_status[s])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// Pin drive, registered
	assign drive_local = |(hw_status[bic_pkg::HW_SYSERR:bic_pkg::HW_PCI_IRQ] & {3{pci_fwd_on}})
		| |(src_status & ~src_cfg_i.dir);
	assign drive_pci = (hw_status[bic_pkg::HW_LOCAL_IRQ] & local_fwd_on)
		| |(src_status & src_cfg_i.dir);

	logic local_drv_q;
	logic pci_drv_q;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			local_drv_q <= 1'b0;
			pci_drv_q   <= 1'b0;
		end else begin
			local_drv_q <= drive_local;
			pci_drv_q   <= drive_pci;
		end
	end

	// Open drain: drive low when asserted, enable active low
	assign local_irq_pin_o      = 1'b0;
	assign local_irq_pin_oe_n_o = ~local_drv_q;
	assign pci_irq_pin_o        = 1'b0;
	assign pci_irq_pin_oe_n_o   = ~pci_drv_q;

	assign src_status_o = src_status;
	assign hw_status_o  = hw_status;

	//////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_pci_irq_held;
		pci_irq_forward_en_i & ~pci_irq_pin_i & pci_irq_pin_oe_n_o;
	endsequence

	sequence s_parity_held;
		parity_line_forward_en_i & ~parity_line_n_i;
	endsequence

	AST_PCI_FWD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		s_pci_irq_held ##1 pci_fwd_on |=> ~local_irq_pin_oe_n_o)
		else $error("local pin not driven for forwarded PCI irq");
	// Status is sticky, so only a fresh set while disabled is an error
	AST_NO_FWD_DIS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(~pci_irq_forward_en_i & ~hw_status[bic_pkg::HW_PCI_IRQ])
		|=> ~hw_status[bic_pkg::HW_PCI_IRQ])
		else $error("forward status set while disabled");
	AST_ONE_DIR: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(pci_fwd_on & ~|(src_status & src_cfg_i.dir)) |=> pci_irq_pin_oe_n_o)
		else $error("both directions active");
	AST_ERR_LINE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		s_parity_held ##1 parity_line_forward_en_i |=> ~local_irq_pin_oe_n_o)
		else $error("parity line not forwarded");
	AST_HW_LOG: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		hw_cause[bic_pkg::HW_SYSERR] |=> hw_status[bic_pkg::HW_SYSERR])
		else $error("system error not logged");
	AST_EN_GATE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(~src_cfg_i.en[bic_pkg::SRC_DMA_DONE] & ~src_status[bic_pkg::SRC_DMA_DONE])
		|=> ~src_status[bic_pkg::SRC_DMA_DONE]) else $error("disabled source set");
	AST_DIR_PCI: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(src_status[bic_pkg::SRC_CFG_STATUS] & src_cfg_i.dir[bic_pkg::SRC_CFG_STATUS])
		|=> ~pci_irq_pin_oe_n_o) else $error("PCI pin not driven by mapped source");
	AST_HOLD: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(src_cfg_i.en[bic_pkg::SRC_DMA_RESET] & dma_flags_i[2]
		& src_status_clr_i[bic_pkg::SRC_DMA_RESET])
		|=> src_status[bic_pkg::SRC_DMA_RESET]) else $error("cleared with flag live");
	AST_MB_SAME: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(~src_status[bic_pkg::SRC_MAILBOX0] & ~src_cfg_i.dir[bic_pkg::SRC_MAILBOX0]
		& ~mb_wr_i.wr_pci[0]) |=> ~src_status[bic_pkg::SRC_MAILBOX0])
		else $error("mailbox fired on same-side write");
	AST_CFG: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(src_cfg_i.en[bic_pkg::SRC_CFG_STATUS] & |cfg_err_bits_i)
		|=> src_status[bic_pkg::SRC_CFG_STATUS])
		else $error("config status not raised");
endmodule // bic_irq_channel

// file: dv/bic_far_model.sv
// Far-side model: PCI agent and local bus master on the two open-drain irq lines.
// Assumes pull-ups on both lines; the testbench commands each agent's pull.
`timescale 1ns/1ps
module bic_far_model (
	// Agent commands
	input  wire logic pci_pull_i,
	input  wire logic local_pull_i,
	// Device drive
	input  wire logic dev_pci_out_i,
	input  wire logic dev_pci_oe_n_i,
	input  wire logic dev_local_out_i,
	input  wire logic dev_local_oe_n_i,
	// Resolved wires
	output logic      pci_wire_o,
	output logic      local_wire_o
);
////////////////////////////////////////////////////////////////////////////////
	// Released line floats to the pull-up, never the last value
	assign pci_wire_o   = ~pci_pull_i & (dev_pci_oe_n_i | dev_pci_out_i);
	assign local_wire_o = ~local_pull_i & (dev_local_oe_n_i | dev_local_out_i);
endmodule // bic_far_model

// file: dv/tb.sv
// Testbench for the interrupt channel: forwarding, internal sources, mailboxes.
// Assumes the far-side model resolves both open-drain pins.
`timescale 1ns/1ps
module tb;
	logic                  core_clk, sys_rst, pci_pull, local_pull, pci_wire, local_wire;
	logic                  pci_out, pci_oe_n, loc_out, loc_oe_n, par_n, sys_n, conflict;
	logic                  f_pel, f_mdp, f_qel, f_qdp;
	logic [3:0]            fw, dma, hw_clr, hw_st;
	logic [4:0]            cfg_err;
	logic [12:0]           src_clr, src_st;
	bic_pkg::bic_src_cfg_t cfg;
	bic_pkg::bic_mb_wr_t   mb;
	int                    n_mismatch = 0;
	int                    total_checks = 0;
////////////////////////////////////////////////////////////////////////////////
	bic_irq_channel u_bic_irq_channel (.core_clk_i(core_clk), .sys_rst_i(sys_rst),
		.pci_irq_pin_i(pci_wire), .pci_irq_pin_o(pci_out), .pci_irq_pin_oe_n_o(pci_oe_n),
		.local_irq_pin_i(local_wire), .local_irq_pin_o(loc_out),
		.local_irq_pin_oe_n_o(loc_oe_n), .parity_line_n_i(par_n), .syserr_line_n_i(sys_n),
		.pci_irq_forward_en_i(fw[0]), .parity_line_forward_en_i(fw[1]),
		.syserr_line_forward_en_i(fw[2]), .local_irq_forward_en_i(fw[3]), .src_cfg_i(cfg),
		.pci_error_log_flag_i(f_pel), .master_parity_flag_i(f_mdp),
		.local_error_log_flag_i(f_qel), .dma_flags_i(dma), .cfg_err_bits_i(cfg_err),
		.local_parity_err_i(f_qdp), .mb_wr_i(mb), .src_status_clr_i(src_clr),
		.hw_status_clr_i(hw_clr), .src_status_o(src_st), .hw_status_o(hw_st),
		.route_conflict_o(conflict));
	bic_far_model u_bic_far_model (.pci_pull_i(pci_pull), .local_pull_i(local_pull),
		.dev_pci_out_i(pci_out), .dev_pci_oe_n_i(pci_oe_n), .dev_local_out_i(loc_out),
		.dev_local_oe_n_i(loc_oe_n), .pci_wire_o(pci_wire), .local_wire_o(local_wire));
////////////////////////////////////////////////////////////////////////////////
	task automatic tick(int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			n_mismatch++;
		end
	endtask
	task automatic chk_pins(logic [1:0] exp);
		chk("pins pci_oe_n local_oe_n", {14'h0000, exp}, {14'h0000, pci_oe_n, loc_oe_n});
	endtask
	task automatic pulse_clr(logic [12:0] s, logic [3:0] h);
		src_clr = s;
		hw_clr = h;
		tick(1);
		src_clr = '0;
		hw_clr = '0;
		tick(1);
	endtask
	task automatic set_hw(int k, logic v);
		case (k)
			0: pci_pull = v;
			1: par_n = ~v;
			2: sys_n = ~v;
			default: local_pull = v;
		endcase
	endtask
	task automatic set_src(int i, logic v);
		case (i)
			0: f_pel = v;
			1: f_mdp = v;
			2: f_qel = v;
			7: cfg_err = {4'h0, v};
			12: f_qdp = v;
			default: dma[i-3] = v;
		endcase
	endtask
////////////////////////////////////////////////////////////////////////////////
	// PCI-side lines forwarded to the local pin, cleared only once negated
	task automatic t_hw_fwd();
		for (int k = 0; k < 3; k++) begin
			fw = '0;
			set_hw(k, 1'b1);
			tick(2);
			chk("hw status disabled", 16'h0000, {12'h000, hw_st});
			chk_pins(2'b11);
			fw[k] = 1'b1;
			tick(2);
			chk("hw status", 16'h0001 << k, {12'h000, hw_st});
			chk_pins(2'b10);
			pulse_clr('0, 4'h1 << k);
			chk("hw status live clear", 16'h0001 << k, {12'h000, hw_st});
			set_hw(k, 1'b0);
			tick(1);
			pulse_clr('0, 4'h1 << k);
			chk("hw status cleared", 16'h0000, {12'h000, hw_st});
			chk_pins(2'b11);
		end
	endtask
	// Local line to PCI pin; refused while a PCI-side forward is on
	task automatic t_loc_fwd();
		fw = 4'h9;
		set_hw(3, 1'b1);
		tick(2);
		chk("conflict", 16'h0001, {15'h0000, conflict});
		chk_pins(2'b11);
		fw = 4'h8;
		tick(2);
		chk("conflict off", 16'h0000, {15'h0000, conflict});
		chk("hw status local", 16'h0008, {12'h000, hw_st});
		chk_pins(2'b01);
		set_hw(3, 1'b0);
		tick(1);
		pulse_clr('0, 4'h8);
		chk("hw status local cleared", 16'h0000, {12'h000, hw_st});
		chk_pins(2'b11);
		fw = '0;
	endtask
	// Each level source alone: enable, direction, sticky clear
	task automatic t_src();
		for (int i = 0; i < 13; i++) begin
			if (i >= 8 && i <= 11) continue;
			cfg.en = '0;
			cfg.dir = {13{i[0]}};
			set_src(i, 1'b1);
			tick(2);
			chk("src status disabled", 16'h0000, {3'h0, src_st});
			cfg.en = '1;
			tick(2);
			chk("src status", 16'h0001 << i, {3'h0, src_st});
			chk_pins({~i[0], i[0]});
			pulse_clr(13'h0001 << i, '0);
			chk("src status live clear", 16'h0001 << i, {3'h0, src_st});
			set_src(i, 1'b0);
			tick(2);
			pulse_clr(13'h0001 << i, '0);
			chk("src status cleared", 16'h0000, {3'h0, src_st});
			chk_pins(2'b11);
		end
	endtask
	// Mailbox writes from the mapped side are ignored
	task automatic t_mb();
		logic [3:0] one;
		for (int m = 0; m < 4; m++) begin
			one = 4'h1 << m;
			cfg.en = '1;
			cfg.dir = {13{m[0]}};
			mb = m[0] ? {one, 4'h0} : {4'h0, one};
			tick(1);
			mb = '0;
			tick(2);
			chk("mailbox same side", 16'h0000, {3'h0, src_st});
			mb = m[0] ? {4'h0, one} : {one, 4'h0};
			tick(1);
			mb = '0;
			tick(1);
			chk("mailbox status", 16'h0100 << m, {3'h0, src_st});
			chk_pins({~m[0], m[0]});
			pulse_clr(13'h0100 << m, '0);
			chk("mailbox cleared", 16'h0000, {3'h0, src_st});
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		#100000;
		$display("[ERR] run timeout expected done seen hung");
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		{sys_rst, par_n, sys_n} = 3'h7;
		{pci_pull, local_pull, f_pel, f_mdp, f_qel, f_qdp} = '0;
		{fw, dma, hw_clr, cfg_err, src_clr, cfg, mb} = '0;
		tick(4);
		sys_rst = 1'b0;
		tick(1);
		chk("reset status", 16'h0000, {hw_st, src_st[11:0]});
		chk("reset src top", 16'h0000, {15'h0000, src_st[12]});
		chk_pins(2'b11);
		chk("pin out levels", 16'h0000, {14'h0000, pci_out, loc_out});
		t_hw_fwd();
		t_loc_fwd();
		t_src();
		t_mb();
		report_and_stop();
	end
endmodule // tb
